/* File: core/axis_read_pkg.sv */
// shared constants and types for the axis value read request path
package axis_read_pkg;
    // parameter-type codes: high byte picks the quantity, low byte the axis
    localparam logic [7:0]  CODE_COUNTER_HI  = 8'h11;
    localparam logic [7:0]  CODE_LATCH_HI    = 8'h12;
    localparam logic [7:0]  CODE_LATCH_ALT_HI = 8'h13;
    localparam logic [7:0]  CODE_AXIS_FIRST  = 8'h01;
    localparam logic [7:0]  CODE_AXIS_LAST   = 8'h10;
    localparam int          AXIS_COUNT       = 16;
    // unit number encodings
    localparam logic [15:0] UNIT_PLAIN_LAST  = 16'h005F;
    localparam logic [11:0] UNIT_ENC_BASE_HI = 12'h800;
    localparam int          UNIT_COUNT       = 16;
    // word counts
    localparam logic [15:0] COUNT_MIN        = 16'h0001;
    localparam logic [15:0] COUNT_MAX        = 16'h0080;
    localparam logic [15:0] COUNT_VALUE      = 16'h0002;
    // quantity selectors driven to unit memory
    localparam logic [1:0]  KIND_COUNTER     = 2'h0;
    localparam logic [1:0]  KIND_LATCH       = 2'h1;
    localparam logic [1:0]  KIND_LATCH_ALT   = 2'h2;
    // controller register offsets (byte addresses)
    localparam logic [7:0]  REG_CONTROL      = 8'h00;
    localparam logic [7:0]  REG_CODE         = 8'h04;
    localparam logic [7:0]  REG_UNIT_COUNT   = 8'h08;
    localparam logic [7:0]  REG_DEST         = 8'h0C;
    localparam logic [7:0]  REG_STATUS       = 8'h10;
    localparam logic [7:0]  REG_IRQ_STATUS   = 8'h14;
    localparam logic [7:0]  REG_IRQ_MASK     = 8'h18;
    localparam logic [7:0]  REG_VALUE_LO     = 8'h1C;
    localparam logic [7:0]  REG_VALUE_HI     = 8'h20;
    // field positions
    localparam int          CTRL_START_BIT   = 0;
    localparam int          STAT_BUSY_BIT    = 0;
    localparam int          STAT_DONE_BIT    = 1;
    localparam int          STAT_ERROR_BIT   = 2;
    localparam int          STAT_WARN_BIT    = 3;
    localparam int          IRQ_DONE_BIT     = 0;
    localparam int          IRQ_ERROR_BIT    = 1;
    localparam int          IRQ_WIDTH        = 2;
    // reset values
    localparam logic [31:0] RESET_WORD       = 32'h0000_0000;
    localparam logic [15:0] RESET_HALF       = 16'h0000;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_CHECK  = 3'b001,
        ST_FETCH  = 3'b010,
        ST_WORD0  = 3'b011,
        ST_WORD1  = 3'b100,
        ST_REPORT = 3'b101
    } unit_state_t;
endpackage : axis_read_pkg

/* File: core/axis_read_if.sv */
// link between the requesting controller and the positioning unit end
`timescale 1ns/1ns
`default_nettype none
interface axis_read_if;
    logic        reqValid;          // held high until reqAck
    logic [15:0] controlCode;       // parameter-type code
    logic [31:0] unitCount;         // count in upper half, unit in lower half
    logic [15:0] destStart;         // first destination word
    logic        reqAck;            // one-cycle result strobe
    logic        requestErrorFlag;
    logic        requestDoneFlag;
    logic        overallWarning;
    logic        dstWrite;          // one-cycle destination word write
    logic [15:0] dstAddr;
    logic [15:0] dstData;

    modport unit_end (
        input  reqValid, controlCode, unitCount, destStart,
        output reqAck, requestErrorFlag, requestDoneFlag, overallWarning,
        output dstWrite, dstAddr, dstData
    );
    modport controller_end (
        output reqValid, controlCode, unitCount, destStart,
        input  reqAck, requestErrorFlag, requestDoneFlag, overallWarning,
        input  dstWrite, dstAddr, dstData
    );
endinterface : axis_read_if
`default_nettype wire

/* File: core/unit_read_request.sv */
// positioning unit end: checks a read request, fetches the value, posts flags
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - codes 1101..1110 select axis feedback counter
// - codes 1201..1210 (and 1301..1310) select latch
// - unit encoded as index plus 8000 hex
// - requester always asks for two words
// - count upper half, unit lower half
// - error when count outside 1..128
// - error when unit outside both ranges
// - error on remote rack or unsupported unit
// - error plus warning on out-of-range data
// - error on any unit fault condition
// - done set on success, cleared otherwise
// - done cleared when next transfer taken
// - busy unit: done cleared, error set
// - words stored consecutively from first destination
// - completes over cycles; requester holds request
// - one request outstanding per unit
// - unit must sit on local racks
module unit_read_request #(
    parameter int UNITS = axis_read_pkg::UNIT_COUNT
) (
    input  wire logic               clk,
    input  wire logic               reset,
    input  wire logic               ce,
    axis_read_if.unit_end           link,
    input  wire logic [UNITS-1:0]   unitSupported,   // unit is a positioning unit on a local rack
    input  wire logic [UNITS-1:0]   unitRemote,      // unit sits on a remote slave rack
    input  wire logic [UNITS-1:0]   unitSettingError,
    input  wire logic [UNITS-1:0]   unitVerifyError,
    input  wire logic [UNITS-1:0]   unitBusSettingError,
    input  wire logic [UNITS-1:0]   unitBusError,
    input  wire logic [UNITS-1:0]   unitBusy,
    output logic                    memReq,          // held until memAck
    output logic [3:0]              memUnit,
    output logic [1:0]              memKind,
    output logic [3:0]              memAxis,
    input  wire logic               memAck,
    input  wire logic [31:0]        memData
);
    import axis_read_pkg::*;

    unit_state_t state;
    logic [15:0] code;
    logic [15:0] unitWord;
    logic [15:0] countWord;
    logic [15:0] dest;
    logic [31:0] value;

    ////////////////////////////////////////////////////////////////////////////
    // operand decoding

    // code decode is shared by the checker and the memory selector
    function automatic logic [6:0] decodeCode(input logic [15:0] c);
        logic       ok;
        logic [1:0] kind;
        ok   = (c[7:0] >= CODE_AXIS_FIRST) && (c[7:0] <= CODE_AXIS_LAST);
        kind = KIND_COUNTER;
        case (c[15:8])
            CODE_COUNTER_HI: begin
                kind = KIND_COUNTER;
            end
            CODE_LATCH_HI: begin
                kind = KIND_LATCH;
            end
            CODE_LATCH_ALT_HI: begin
                kind = KIND_LATCH_ALT;
            end
            default: begin
                ok = 1'b0;
            end
        endcase
        decodeCode = {ok, kind, 4'(c[7:0] - CODE_AXIS_FIRST)};
    endfunction : decodeCode

    logic [6:0] codeInfo;
    logic       isPlainUnit;
    logic       isEncodedUnit;
    logic [3:0] unitIdx;
    logic       countBad;
    logic       unitBad;
    logic       typeBad;
    logic       faultBad;
    logic       dataBad;

    // the plain range names non-positioning units, so it passes the range check
    // but always fails the type check
    always_comb begin
        codeInfo      = decodeCode(code);
        isPlainUnit   = unitWord <= UNIT_PLAIN_LAST;
        isEncodedUnit = unitWord[15:4] == UNIT_ENC_BASE_HI;
        unitIdx       = unitWord[3:0];
        countBad      = (countWord < COUNT_MIN) || (countWord > COUNT_MAX);
        unitBad       = !(isPlainUnit || isEncodedUnit);
        typeBad       = isPlainUnit || !unitSupported[unitIdx]
                      || unitRemote[unitIdx];
        faultBad      = unitSettingError[unitIdx] || unitVerifyError[unitIdx]
                      || unitBusSettingError[unitIdx] || unitBusError[unitIdx];
        dataBad       = !codeInfo[6] || (countWord != COUNT_VALUE);
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer: the request is serviced over several cycles, never at once

    always_ff @(posedge clk) begin
        if (reset) begin
            state <= ST_IDLE;
        end else if (ce) begin
            case (state)
                ST_IDLE: begin
                    // the strobe cycle still shows the old request raised; taking it would rerun it
                    if (link.reqValid && !link.reqAck) begin
                        state <= ST_CHECK;
                    end
                end
                ST_CHECK: begin
                    if (countBad || unitBad || typeBad || faultBad || unitBusy[unitIdx] || dataBad) begin
                        state <= ST_REPORT;
                    end else begin
                        state <= ST_FETCH;
                    end
                end
                ST_FETCH: begin
                    if (memAck) begin
                        state <= ST_WORD0;
                    end
                end
                ST_WORD0: begin
                    state <= ST_WORD1;
                end
                ST_WORD1: begin
                    state <= ST_REPORT;
                end
                ST_REPORT: begin
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // operands are captured once; the requester keeps them stable anyway
    always_ff @(posedge clk) begin
        if (reset) begin
            code      <= RESET_HALF;
            unitWord  <= RESET_HALF;
            countWord <= RESET_HALF;
            dest      <= RESET_HALF;
        end else if (ce && state == ST_IDLE && link.reqValid && !link.reqAck) begin
            code      <= link.controlCode;
            unitWord  <= link.unitCount[15:0];
            countWord <= link.unitCount[31:16];
            dest      <= link.destStart;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // unit memory fetch

    always_ff @(posedge clk) begin
        if (reset) begin
            memReq  <= 1'b0;
            memUnit <= 4'h0;
            memKind <= 2'h0;
            memAxis <= 4'h0;
            value   <= RESET_WORD;
        end else if (ce) begin
            if (state == ST_CHECK && !(countBad || unitBad || typeBad || faultBad
                                       || unitBusy[unitIdx] || dataBad)) begin
                memReq  <= 1'b1;
                memUnit <= unitIdx;
                memKind <= codeInfo[5:4];
                memAxis <= codeInfo[3:0];
            end else if (state == ST_FETCH && memAck) begin
                memReq  <= 1'b0;
                value   <= memData;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // destination word writes: two consecutive words, low half first

    always_ff @(posedge clk) begin
        if (reset) begin
            link.dstWrite <= 1'b0;
            link.dstAddr  <= RESET_HALF;
            link.dstData  <= RESET_HALF;
        end else if (ce) begin
            link.dstWrite <= 1'b0;
            if (state == ST_WORD0) begin
                link.dstWrite <= 1'b1;
                link.dstAddr  <= dest;
                link.dstData  <= value[15:0];
            end else if (state == ST_WORD1) begin
                link.dstWrite <= 1'b1;
                link.dstAddr  <= 16'(dest + 16'h0001);
                link.dstData  <= value[31:16];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // result flags: levels that hold until the next request is taken

    always_ff @(posedge clk) begin
        if (reset) begin
            link.requestErrorFlag <= 1'b0;
            link.requestDoneFlag  <= 1'b0;
            link.overallWarning   <= 1'b0;
        end else if (ce) begin
            case (state)
                ST_IDLE: begin
                    if (link.reqValid && !link.reqAck) begin
                        link.requestDoneFlag  <= 1'b0;
                        link.requestErrorFlag <= 1'b0;
                        link.overallWarning   <= 1'b0;
                    end
                end
                ST_CHECK: begin
                    if (countBad || unitBad || typeBad || faultBad) begin
                        link.requestErrorFlag <= 1'b1;
                        link.requestDoneFlag  <= 1'b0;
                    end else if (unitBusy[unitIdx]) begin
                        link.requestErrorFlag <= 1'b1;
                        link.requestDoneFlag  <= 1'b0;
                    end else if (dataBad) begin
                        link.requestErrorFlag <= 1'b1;
                        link.overallWarning   <= 1'b1;
                        link.requestDoneFlag  <= 1'b0;
                    end
                end
                ST_WORD1: begin
                    link.requestDoneFlag <= 1'b1;
                end
                default: begin
                end
            endcase
        end
    end

    // the strobe tells the requester that the flags now hold this request's result
    always_ff @(posedge clk) begin
        if (reset) begin
            link.reqAck <= 1'b0;
        end else if (ce) begin
            link.reqAck <= (state == ST_REPORT) && !link.reqAck;
        end
    end
endmodule : unit_read_request
`default_nettype wire

/* File: core/read_request_controller.sv */
// requesting controller end: APB registers, request hold loop, interrupt
`timescale 1ns/1ns
`default_nettype none
module read_request_controller (
    input  wire logic               clk,
    input  wire logic               reset,
    input  wire logic               ce,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    output logic                    irq,
    axis_read_if.controller_end     link
);
    import axis_read_pkg::*;

    logic                 busy;
    logic                 doneSeen;
    logic                 errorSeen;
    logic                 warnSeen;
    logic [IRQ_WIDTH-1:0] irqStatus;
    logic [IRQ_WIDTH-1:0] irqMask;
    logic [15:0]          valueLo;
    logic [15:0]          valueHi;
    logic                 wrEn;
    logic                 startReq;
    logic [IRQ_WIDTH-1:0] irqSet;
    logic [IRQ_WIDTH-1:0] next_irqStatus;

    ////////////////////////////////////////////////////////////////////////////
    // bus decode: access phase lasts exactly one cycle

    always_comb begin
        wrEn     = psel && penable && pwrite && pready;
        startReq = wrEn && paddr == REG_CONTROL && pwdata[CTRL_START_BIT] && !busy;
        irqSet   = '0;
        if (link.reqAck) begin
            irqSet[IRQ_DONE_BIT]  = link.requestDoneFlag;
            irqSet[IRQ_ERROR_BIT] = link.requestErrorFlag;
        end
        // a new event wins over a write-one clear in the same cycle
        next_irqStatus = irqStatus;
        if (wrEn && paddr == REG_IRQ_STATUS) begin
            next_irqStatus = irqStatus & ~pwdata[IRQ_WIDTH-1:0];
        end
        next_irqStatus = next_irqStatus | irqSet;
    end

    // writes take effect only at the edge that completes the transfer, where
    // pready is sampled high; read data is registered in the setup cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= RESET_WORD;
        end else if (ce) begin
            pready  <= psel && !penable && !pready;
            pslverr <= 1'b0;
            prdata  <= RESET_WORD;
            if (psel && !penable && !pready) begin
                case (paddr)
                    REG_CONTROL:    prdata <= RESET_WORD;
                    REG_CODE:       prdata <= {16'h0000, link.controlCode};
                    REG_UNIT_COUNT: prdata <= link.unitCount;
                    REG_DEST:       prdata <= {16'h0000, link.destStart};
                    REG_STATUS:     prdata <= {28'h0000000, warnSeen, errorSeen, doneSeen, busy};
                    REG_IRQ_STATUS: prdata <= {30'h0, irqStatus};
                    REG_IRQ_MASK:   prdata <= {30'h0, irqMask};
                    REG_VALUE_LO:   prdata <= {16'h0000, valueLo};
                    REG_VALUE_HI:   prdata <= {16'h0000, valueHi};
                    default:        pslverr <= 1'b1;    // unmapped: error, reads zero
                endcase
            end
        end
    end

    // operand registers; frozen while a request is outstanding
    always_ff @(posedge clk) begin
        if (reset) begin
            link.controlCode <= RESET_HALF;
            link.unitCount   <= RESET_WORD;
            link.destStart   <= RESET_HALF;
            irqMask          <= '0;
        end else if (ce && wrEn) begin
            if (paddr == REG_CODE && !busy) begin
                link.controlCode <= pwdata[15:0];
            end
            if (paddr == REG_UNIT_COUNT && !busy) begin
                link.unitCount <= pwdata;
            end
            if (paddr == REG_DEST && !busy) begin
                link.destStart <= pwdata[15:0];
            end
            if (paddr == REG_IRQ_MASK) begin
                irqMask <= pwdata[IRQ_WIDTH-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // request loop: the request stays raised until the result strobe comes

    always_ff @(posedge clk) begin
        if (reset) begin
            busy          <= 1'b0;
            link.reqValid <= 1'b0;
        end else if (ce) begin
            if (link.reqAck) begin
                busy          <= 1'b0;
                link.reqValid <= 1'b0;
            end else if (startReq) begin
                busy          <= 1'b1;
                link.reqValid <= 1'b1;
            end
        end
    end

    // result capture: flags latched at the strobe, words at each write
    always_ff @(posedge clk) begin
        if (reset) begin
            doneSeen  <= 1'b0;
            errorSeen <= 1'b0;
            warnSeen  <= 1'b0;
            valueLo   <= RESET_HALF;
            valueHi   <= RESET_HALF;
        end else if (ce) begin
            if (startReq) begin
                doneSeen  <= 1'b0;
                errorSeen <= 1'b0;
                warnSeen  <= 1'b0;
            end else if (link.reqAck) begin
                doneSeen  <= link.requestDoneFlag;
                errorSeen <= link.requestErrorFlag;
                warnSeen  <= link.overallWarning;
            end
            if (link.dstWrite && link.dstAddr == link.destStart) begin
                valueLo <= link.dstData;
            end else if (link.dstWrite && link.dstAddr == 16'(link.destStart + 16'h0001)) begin
                valueHi <= link.dstData;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt: sticky status, write one to clear, masked onto one level

    always_ff @(posedge clk) begin
        if (reset) begin
            irqStatus <= '0;
            irq       <= 1'b0;
        end else if (ce) begin
            irqStatus <= next_irqStatus;
            irq       <= |(next_irqStatus & irqMask);
        end
    end
endmodule : read_request_controller
`default_nettype wire

/* File: tb/axis_read_sva.sv */
// concurrent checks on the link between the controller end and the unit end
`timescale 1ns/1ns
`default_nettype none
module axis_read_sva (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        reqValid,
    input wire logic        reqAck,
    input wire logic        requestErrorFlag,
    input wire logic        requestDoneFlag,
    input wire logic        overallWarning,
    input wire logic        dstWrite,
    input wire logic [15:0] dstAddr,
    input wire logic [15:0] destStart
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////////////
    // a value lands as two adjacent words, low half first
    sequence lowHalf; dstWrite && dstAddr == destStart; endsequence
    sequence highHalf; dstWrite && dstAddr == 16'(destStart + 16'h1); endsequence
    chk_half_order: assert property (lowHalf |=> highHalf)
        else $error("high half not written next");
    chk_done_ack: assert property (highHalf |-> requestDoneFlag ##1 reqAck)
        else $error("done or ack missing after value");
    // bounded answer: the request is never left hanging
    chk_ack_bound: assert property ($rose(reqValid) |-> ##[3:12] reqAck)
        else $error("request not answered in time");
    chk_ack_pulse: assert property (reqAck |=> !reqAck)
        else $error("ack longer than one cycle");
    chk_ack_held: assert property (reqAck |-> reqValid)
        else $error("ack without pending request");
    chk_flag_clear: assert property ($rose(reqValid) |=> !requestDoneFlag && !requestErrorFlag)
        else $error("old flags survive a new request");
    chk_one_result: assert property (reqAck |-> requestDoneFlag != requestErrorFlag)
        else $error("done and error not exclusive");
    chk_warn_error: assert property (overallWarning |-> requestErrorFlag)
        else $error("warning without error");
    chk_error_nowrite: assert property (requestErrorFlag |-> !dstWrite)
        else $error("destination written on error");
endmodule : axis_read_sva
`default_nettype wire

/* File: tb/axis_value_read_request_tb_top.sv */
// self-checking bench joining the controller end to the unit end
`timescale 1ns/1ns
`default_nettype none
module axis_value_read_request_tb_top;
    import axis_read_pkg::*;
    logic        clk, reset, psel, penable, pwrite, pready, pslverr, irq, memReq, memAck;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, memData, r;
    logic [3:0]  memUnit, memAxis;
    logic [1:0]  memKind;
    logic [15:0] sup, rem, fSet, fVer, fBset, fBus, busy;
    int          miscompares = 0;
    int          comparisons = 0;
    axis_read_if link ();
    unit_read_request u_unit_read_request (.clk(clk), .reset(reset), .ce(1'b1), .link(link.unit_end),
        .unitSupported(sup), .unitRemote(rem), .unitSettingError(fSet), .unitVerifyError(fVer),
        .unitBusSettingError(fBset), .unitBusError(fBus), .unitBusy(busy), .memReq(memReq),
        .memUnit(memUnit), .memKind(memKind), .memAxis(memAxis), .memAck(memAck), .memData(memData));
    read_request_controller u_read_request_controller (.clk(clk), .reset(reset), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .link(link.controller_end));
    axis_read_sva u_axis_read_sva (.clk(clk), .reset(reset), .reqValid(link.reqValid), .reqAck(link.reqAck),
        .requestErrorFlag(link.requestErrorFlag), .requestDoneFlag(link.requestDoneFlag),
        .overallWarning(link.overallWarning), .dstWrite(link.dstWrite), .dstAddr(link.dstAddr),
        .destStart(link.destStart));
    ////////////////////////////////////////////////////////////////////////
    // pattern that names unit, quantity and axis so a wrong fetch shows up
    function automatic logic [31:0] val(logic [3:0] u, logic [1:0] k, logic [3:0] a);
        return {8'hA5, 4'h0, u, 6'h0, k, 4'h0, a};
    endfunction : val
    // unit memory answers one cycle after the fetch; data is scrambled when idle
    always @(posedge clk) begin
        if (reset) begin
            memAck  <= 1'b0;
            memData <= 32'h0000_0000;
        end else begin
            memAck  <= memReq && !memAck;
            memData <= memReq ? val(memUnit, memKind, memAxis) : ~memData;
        end
    end
    initial begin
        clk = 0;
        forever #10 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic conclude;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : conclude
    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : check
    // one apb transfer; an idle edge first keeps back-to-back calls race free
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1;
        n = 0;
        do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin miscompares++; conclude(); end
        q = w ? {31'h0, pslverr} : prdata;
        psel <= 0; penable <= 0;
    endtask : bus
    // program one request, start it, poll until idle and judge the status
    task automatic run(input logic [15:0] code, input logic [31:0] uc, input logic [3:0] st);
        int n;
        bus(1, REG_CODE, {16'h0, code}, r);
        bus(1, REG_UNIT_COUNT, uc, r);
        bus(1, REG_DEST, 32'h0000_0040, r);
        bus(1, REG_CONTROL, 32'h0000_0001, r);
        r = 32'h1;
        for (n = 0; n < 40 && r[0] !== 1'b0; n++) bus(0, REG_STATUS, 32'h0, r);
        check("status", {28'h0, st}, r);
    endtask : run
    task automatic t_read(input logic [15:0] code, input logic [3:0] u, input logic [1:0] k, input logic [3:0] a);
        logic [31:0] v;
        v = val(u, k, a);
        run(code, {16'h0002, 12'h800, u}, 4'h2);
        bus(0, REG_VALUE_LO, 32'h0, r);
        check("value low", {16'h0, v[15:0]}, r);
        bus(0, REG_VALUE_HI, 32'h0, r);
        check("value high", {16'h0, v[31:16]}, r);
    endtask : t_read
    task automatic t_errors;
        sup <= 16'hFFBF; rem <= 16'h0010; fSet <= 16'h0080; fVer <= 16'h0200; fBset <= 16'h0400;
        fBus <= 16'h0800; busy <= 16'h0100;
        run(16'h1101, 32'h0081_8003, 4'h4);
        run(16'h1101, 32'h0000_8003, 4'h4);
        run(16'h1101, 32'h0080_8003, 4'hC);
        run(16'h1101, 32'h0002_0060, 4'h4);
        run(16'h1101, 32'h0002_8010, 4'h4);
        run(16'h1101, 32'h0002_0005, 4'h4);
        run(16'h1101, 32'h0002_8004, 4'h4);
        run(16'h1101, 32'h0002_8006, 4'h4);
        for (int i = 7; i < 12; i++) run(16'h1101, {16'h0002, 12'h800, 4'(i)}, 4'h4);
        run(16'h1101, 32'h0003_8003, 4'hC);
        run(16'h1111, 32'h0002_8003, 4'hC);
        run(16'h1401, 32'h0002_8003, 4'hC);
    endtask : t_errors
    // interrupt: pending events, mask, write-one clear, masked error
    task automatic t_irq;
        bus(0, REG_IRQ_STATUS, 32'h0, r);
        check("irq status", 32'h3, r);
        bus(1, REG_IRQ_MASK, 32'h1, r);
        repeat (2) @(posedge clk);
        check("irq masked in", 32'h1, {31'h0, irq});
        bus(1, REG_IRQ_STATUS, 32'h3, r);
        run(16'h1101, 32'h0002_0061, 4'h4);
        repeat (2) @(posedge clk);
        check("irq masked out", 32'h0, {31'h0, irq});
        bus(0, REG_IRQ_STATUS, 32'h0, r);
        check("irq status err", 32'h2, r);
    endtask : t_irq
    ////////////////////////////////////////////////////////////////////////
    initial begin
        reset = 1; psel = 0; penable = 0; pwrite = 0; paddr = 8'h0; pwdata = 32'h0;
        sup = 16'hFFFF; rem = 16'h0; fSet = 16'h0; fVer = 16'h0;
        fBset = 16'h0; fBus = 16'h0; busy = 16'h0;
        repeat (16) @(posedge clk);
        reset <= 0;
        bus(0, REG_STATUS, 32'h0, r);
        check("status reset", 32'h0, r);
        bus(1, 8'h24, 32'h1, r);
        check("unmapped refused", 32'h1, r);
        t_read(16'h1101, 4'h3, 2'h0, 4'h0);
        t_read(16'h1110, 4'hF, 2'h0, 4'hF);
        t_read(16'h1201, 4'h0, 2'h1, 4'h0);
        t_read(16'h1210, 4'h3, 2'h1, 4'hF);
        t_read(16'h1301, 4'h3, 2'h2, 4'h0);
        t_errors();
        t_irq();
        conclude();
    end
endmodule : axis_value_read_request_tb_top
`default_nettype wire
